// file: verilog/tmr_pkg.sv
package tmr_pkg;
   // read addresses
   localparam logic [7:0] RD_LOCAL_RESULT = 8'h00;
   localparam logic [7:0] RD_EXT_RESULT_HI = 8'h01;
   localparam logic [7:0] RD_STATUS = 8'h02;
   localparam logic [7:0] RD_CONFIG = 8'h03;
   localparam logic [7:0] RD_CADENCE = 8'h04;
   localparam logic [7:0] RD_LOCAL_HIGH = 8'h05;
   localparam logic [7:0] RD_LOCAL_LOW = 8'h06;
   localparam logic [7:0] RD_EXT_HIGH_HI = 8'h07;
   localparam logic [7:0] RD_EXT_LOW_HI = 8'h08;
   localparam logic [7:0] RD_EXT_RESULT_LO = 8'h10;
   // write addresses
   localparam logic [7:0] WR_CONFIG = 8'h09;
   localparam logic [7:0] WR_CADENCE = 8'h0a;
   localparam logic [7:0] WR_LOCAL_HIGH = 8'h0b;
   localparam logic [7:0] WR_LOCAL_LOW = 8'h0c;
   localparam logic [7:0] WR_EXT_HIGH_HI = 8'h0d;
   localparam logic [7:0] WR_EXT_LOW_HI = 8'h0e;
   localparam logic [7:0] WR_ONE_SHOT = 8'h0f;
   // same address for read and write
   localparam logic [7:0] RW_EXT_OFFSET_HI = 8'h11;
   localparam logic [7:0] RW_EXT_OFFSET_LO = 8'h12;
   localparam logic [7:0] RW_EXT_HIGH_LO = 8'h13;
   localparam logic [7:0] RW_EXT_LOW_LO = 8'h14;
   localparam logic [7:0] RW_EXT_SHUTDOWN = 8'h19;
   localparam logic [7:0] RW_LOCAL_SHUTDOWN = 8'h20;
   localparam logic [7:0] RW_HYSTERESIS = 8'h21;
   localparam logic [7:0] RW_FAULT_QUEUE = 8'h22;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_CONFIG = 8'h00;
   localparam logic [7:0] RST_CADENCE = 8'h06;
   localparam logic [7:0] RST_HIGH_LIMIT = 8'h55;
   localparam logic [7:0] RST_SHUTDOWN = 8'h55;
   localparam logic [7:0] RST_HYSTERESIS = 8'h0a;
   localparam logic [7:0] RST_FAULT_QUEUE = 8'h01;
   // writable bits
   localparam logic [7:0] MASK_CONFIG = 8'hf4;
   localparam logic [7:0] MASK_CADENCE = 8'h0f;
   localparam logic [7:0] MASK_FAULT_QUEUE = 8'hcf;
   // field positions
   localparam int CFG_ALERT_MASK = 7;
   localparam int CFG_STANDBY = 6;
   localparam int CFG_PIN_SHUTDOWN = 5;
   localparam int CFG_BETA_OFF = 4;
   localparam int CFG_WIDE_RANGE = 2;
   localparam int FQ_SCL_TIMEOUT = 7;
   localparam int FQ_SDA_TIMEOUT = 6;
   localparam int ST_BUSY = 7;
   // timing: one millisecond base tick at a 4 ns clock
   localparam int CLK_PERIOD_PS = 4000;
   localparam int TICK_MS_PS = 1000000000;
   localparam int TICK_CYCLES = TICK_MS_PS / CLK_PERIOD_PS;
   localparam int CADENCE_MAX_CODE = 10;
   // conversion periods in ms for codes 0..10
   localparam logic [15:0] PERIOD_MS [0:10] = '{
      16'd16000, 16'd8000, 16'd4000, 16'd2000, 16'd1000, 16'd500,
      16'd250, 16'd200, 16'd100, 16'd50, 16'd27};
endpackage

// file: verilog/tmr_register_map.sv
// Notes on behaviour
// - rate code bits 3:0 pick conversion cadence
// - status bit 7 shows conversion in progress
// - bits 6,5 flag local high, low trip
// - bits 4,3 flag external high, low trip
// - bit 2 flags open external sensor
// - bits 1,0 flag external, local shutdown trip
// - bits 6..2 sticky until status read
// - bits 6..2 drive alert; in pin shutdown mode only bit 1 does
// - fault queue bit 7 enables clock timeout
// - fault queue bit 6 enables data timeout
// - fault queue count selects 1 to 4
// - result registers read-only, reset zero
// - local limits: read 05/06, write 0B/0C
// - external limit high bytes: read 07/08, write 0D/0E
// - offset bytes 11,12 read-write, reset zero
// - limit low bytes 13,14 read-write, reset zero
// - shutdown limits and hysteresis read-write
// - alert mask only when pin is alert
// - standby stops timed conversions, limits still update
module tmr_register_map
   import tmr_pkg::*;
#(
   parameter int TICK_LEN = tmr_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // register access from the bus framing logic
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // measurement front end
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [7:0] local_meas,
   input wire logic [15:0] ext_meas,
   input wire logic ext_open,
   // pins and settings
   output logic alert_pin_n,
   output logic shutdown_output_n,
   output logic scl_timeout_en,
   output logic sda_timeout_en,
   output logic wide_range,
   output logic beta_disable
);
   import tmr_pkg::*;

   function automatic logic [7:0] masked(input logic [7:0] d,
                                         input logic [7:0] m);
      return d & m;
   endfunction

   // shutdown trips above limit, releases below limit minus hysteresis
   // the release point wraps if hysteresis exceeds the limit
   function automatic logic shut_next(input logic [15:0] t,
                                      input logic [15:0] lim,
                                      input logic [7:0] hyst,
                                      input logic cur);
      logic [15:0] rel;
      rel = lim - {hyst, 8'h00};
      if (t > lim)
         return 1'b1;
      else if (t < rel)
         return 1'b0;
      else
         return cur;
   endfunction

   logic [7:0] local_result_reg, ext_result_hi_reg, ext_result_lo_reg;
   logic [7:0] config_reg, cadence_reg, fault_queue_reg;
   logic [7:0] local_high_reg, local_low_reg;
   logic [7:0] ext_high_hi_reg, ext_low_hi_reg;
   logic [7:0] ext_high_lo_reg, ext_low_lo_reg;
   logic [7:0] ext_offset_hi_reg, ext_offset_lo_reg;
   logic [7:0] ext_shutdown_reg, local_shutdown_reg, hysteresis_reg;
   logic [4:0] sticky_reg;
   logic busy_reg;
   logic open_reg;
   logic local_shut_reg, ext_shut_reg;
   logic conv_eval_reg, limit_eval_reg;
   logic [2:0] oor_cnt_reg;
   logic [31:0] tick_cnt_reg;
   logic [15:0] ms_cnt_reg;
   logic one_shot_reg;

   logic wr_limit;
   logic status_read;
   logic [15:0] ext_now, ext_high, ext_low;
   logic [16:0] ext_sum;
   logic [4:0] cond_now;
   logic [15:0] period_ms;
   logic [2:0] queue_need;
   logic queue_met;
   logic period_hit;
   logic [7:0] status_now;
   logic alert_raise;

   assign wr_limit = reg_wr &&
      (reg_addr == WR_LOCAL_HIGH || reg_addr == WR_LOCAL_LOW ||
       reg_addr == WR_EXT_HIGH_HI || reg_addr == WR_EXT_LOW_HI ||
       reg_addr == RW_EXT_HIGH_LO || reg_addr == RW_EXT_LOW_LO ||
       reg_addr == RW_EXT_SHUTDOWN || reg_addr == RW_LOCAL_SHUTDOWN ||
       reg_addr == RW_HYSTERESIS);
   // a status read is what clears the sticky flags
   assign status_read = reg_rd && reg_addr == RD_STATUS;

   // external reading with the calibration offset folded in
   // the sum wraps at 16 bits; an offset past full scale is not clipped
   assign ext_sum = {1'b0, ext_meas} +
                    {1'b0, ext_offset_hi_reg, ext_offset_lo_reg};
   assign ext_now = {ext_result_hi_reg, ext_result_lo_reg};
   assign ext_high = {ext_high_hi_reg, ext_high_lo_reg};
   assign ext_low = {ext_low_hi_reg, ext_low_lo_reg};

   // live trip conditions, order matches status bits 6..2
   // comparisons are unsigned, so below-zero codes compare high
   always_comb begin
      cond_now[4] = local_result_reg > local_high_reg;
      cond_now[3] = local_result_reg < local_low_reg;
      cond_now[2] = ext_now > ext_high;
      cond_now[1] = ext_now < ext_low;
      cond_now[0] = open_reg;
   end

   // codes above the table run at the fastest rate
   always_comb begin
      if (cadence_reg[3:0] > 4'(CADENCE_MAX_CODE))
         period_ms = PERIOD_MS[CADENCE_MAX_CODE];
      else
         period_ms = PERIOD_MS[cadence_reg[3:0]];
   end

   // the low bit of the queue field is ignored
   always_comb begin
      unique case (fault_queue_reg[3:1])
         3'b000: queue_need = 3'd1;
         3'b001: queue_need = 3'd2;
         3'b011: queue_need = 3'd3;
         3'b111: queue_need = 3'd4;
         default: queue_need = 3'd1;
      endcase
   end
   assign queue_met = oor_cnt_reg >= queue_need;

   // the period ends on the last cycle of its last millisecond
   assign period_hit = tick_cnt_reg == 32'(TICK_LEN - 1) &&
                       ms_cnt_reg >= period_ms - 16'd1;

   // cadence timer: ms base tick, then ms count up to the period
   // standby holds the timer at zero so a resume starts a full period
   always_ff @(posedge clock) begin
      if (srst) begin
         tick_cnt_reg <= '0;
         ms_cnt_reg <= '0;
      end else if (config_reg[CFG_STANDBY]) begin
         tick_cnt_reg <= '0;
         ms_cnt_reg <= '0;
      end else if (tick_cnt_reg == 32'(TICK_LEN - 1)) begin
         tick_cnt_reg <= '0;
         if (period_hit)
            ms_cnt_reg <= '0;
         else
            ms_cnt_reg <= ms_cnt_reg + 16'd1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'd1;
      end
   end

   // a one-shot written during a conversion waits until it ends
   always_ff @(posedge clock) begin
      if (srst)
         one_shot_reg <= 1'b0;
      else if (reg_wr && reg_addr == WR_ONE_SHOT)
         one_shot_reg <= 1'b1;
      else if (!busy_reg)
         one_shot_reg <= 1'b0;
   end

   // conversion start and busy
   // a period that ends mid-conversion is skipped, not queued
   always_ff @(posedge clock) begin
      if (srst) begin
         conv_start <= 1'b0;
         busy_reg <= 1'b0;
      end else if (!busy_reg &&
                   ((period_hit && !config_reg[CFG_STANDBY]) ||
                    one_shot_reg)) begin
         conv_start <= 1'b1;
         busy_reg <= 1'b1;
      end else begin
         conv_start <= 1'b0;
         if (conv_done)
            busy_reg <= 1'b0;
      end
   end

   // results load only at the end of a started conversion
   always_ff @(posedge clock) begin
      if (srst) begin
         local_result_reg <= RST_ZERO;
         ext_result_hi_reg <= RST_ZERO;
         ext_result_lo_reg <= RST_ZERO;
         open_reg <= 1'b0;
      end else if (busy_reg && conv_done) begin
         local_result_reg <= local_meas;
         ext_result_hi_reg <= ext_sum[15:8];
         ext_result_lo_reg <= ext_sum[7:0];
         open_reg <= ext_open;
      end
   end

   // compare one cycle after new data or a limit change
   // limit writes re-run the compare so standby still updates flags
   always_ff @(posedge clock) begin
      if (srst) begin
         conv_eval_reg <= 1'b0;
         limit_eval_reg <= 1'b0;
      end else begin
         conv_eval_reg <= busy_reg && conv_done;
         limit_eval_reg <= wr_limit;
      end
   end

   // consecutive out-of-limit conversions
   // the count saturates at four, the deepest queue setting
   always_ff @(posedge clock) begin
      if (srst)
         oor_cnt_reg <= '0;
      else if (conv_eval_reg) begin
         if (|cond_now[4:1] && oor_cnt_reg != 3'd4)
            oor_cnt_reg <= oor_cnt_reg + 3'd1;
         else if (!(|cond_now[4:1]))
            oor_cnt_reg <= '0;
      end
   end

   // sticky flags: a set in the read cycle wins over the clear
   always_ff @(posedge clock) begin
      if (srst)
         sticky_reg <= '0;
      else
         sticky_reg <= (status_read ? 5'h00 : sticky_reg) |
            ((conv_eval_reg || limit_eval_reg) ? cond_now : 5'h00);
   end

   // shutdown flags follow the limits with hysteresis, always live
   always_ff @(posedge clock) begin
      if (srst) begin
         local_shut_reg <= 1'b0;
         ext_shut_reg <= 1'b0;
      end else begin
         local_shut_reg <= shut_next({local_result_reg, 8'h00},
            {local_shutdown_reg, 8'h00}, hysteresis_reg,
            local_shut_reg);
         ext_shut_reg <= shut_next(ext_now, {ext_shutdown_reg, 8'h00},
            hysteresis_reg, ext_shut_reg);
      end
   end

   // open sensor raises alert at once; limit trips wait for the queue
   assign alert_raise = (|sticky_reg[4:1] && queue_met) ||
                        sticky_reg[0];

   // shutdown pin follows either live shutdown flag
   always_ff @(posedge clock) begin
      if (srst)
         shutdown_output_n <= 1'b1;
      else
         shutdown_output_n <= !(local_shut_reg || ext_shut_reg);
   end

   // alert pin; busy never reaches it, external shutdown only in pin shutdown mode
   always_ff @(posedge clock) begin
      if (srst)
         alert_pin_n <= 1'b1;
      else if (config_reg[CFG_PIN_SHUTDOWN])
         alert_pin_n <= !ext_shut_reg;
      else
         alert_pin_n <= !(alert_raise &&
                          !config_reg[CFG_ALERT_MASK]);
   end

   // control registers: reserved bits are dropped on the way in
   always_ff @(posedge clock) begin
      if (srst) begin
         config_reg <= RST_CONFIG;
         cadence_reg <= RST_CADENCE;
         fault_queue_reg <= RST_FAULT_QUEUE;
      end else if (reg_wr) begin
         unique case (reg_addr)
            WR_CONFIG: config_reg <= masked(reg_wdata, MASK_CONFIG);
            WR_CADENCE:
               cadence_reg <= masked(reg_wdata, MASK_CADENCE);
            RW_FAULT_QUEUE:
               fault_queue_reg <= masked(reg_wdata, MASK_FAULT_QUEUE);
            default: ;
         endcase
      end
   end

   // limit, offset and hysteresis registers take the whole byte
   always_ff @(posedge clock) begin
      if (srst) begin
         local_high_reg <= RST_HIGH_LIMIT;
         local_low_reg <= RST_ZERO;
         ext_high_hi_reg <= RST_HIGH_LIMIT;
         ext_low_hi_reg <= RST_ZERO;
         ext_offset_hi_reg <= RST_ZERO;
         ext_offset_lo_reg <= RST_ZERO;
         ext_high_lo_reg <= RST_ZERO;
         ext_low_lo_reg <= RST_ZERO;
         ext_shutdown_reg <= RST_SHUTDOWN;
         local_shutdown_reg <= RST_SHUTDOWN;
         hysteresis_reg <= RST_HYSTERESIS;
      end else if (reg_wr) begin
         unique case (reg_addr)
            WR_LOCAL_HIGH: local_high_reg <= reg_wdata;
            WR_LOCAL_LOW: local_low_reg <= reg_wdata;
            WR_EXT_HIGH_HI: ext_high_hi_reg <= reg_wdata;
            WR_EXT_LOW_HI: ext_low_hi_reg <= reg_wdata;
            RW_EXT_OFFSET_HI: ext_offset_hi_reg <= reg_wdata;
            RW_EXT_OFFSET_LO: ext_offset_lo_reg <= reg_wdata;
            RW_EXT_HIGH_LO: ext_high_lo_reg <= reg_wdata;
            RW_EXT_LOW_LO: ext_low_lo_reg <= reg_wdata;
            RW_EXT_SHUTDOWN: ext_shutdown_reg <= reg_wdata;
            RW_LOCAL_SHUTDOWN: local_shutdown_reg <= reg_wdata;
            RW_HYSTERESIS: hysteresis_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   assign status_now = {busy_reg, sticky_reg,
                        ext_shut_reg, local_shut_reg};

   // read data is registered; result addresses have no write path
   // unmapped addresses read as zero rather than holding old data
   always_ff @(posedge clock) begin
      if (srst)
         reg_rdata <= 8'h00;
      else if (reg_rd) begin
         unique case (reg_addr)
            RD_LOCAL_RESULT: reg_rdata <= local_result_reg;
            RD_EXT_RESULT_HI: reg_rdata <= ext_result_hi_reg;
            RD_EXT_RESULT_LO: reg_rdata <= ext_result_lo_reg;
            RD_STATUS: reg_rdata <= status_now;
            RD_CONFIG: reg_rdata <= config_reg;
            RD_CADENCE: reg_rdata <= cadence_reg;
            RD_LOCAL_HIGH: reg_rdata <= local_high_reg;
            RD_LOCAL_LOW: reg_rdata <= local_low_reg;
            RD_EXT_HIGH_HI: reg_rdata <= ext_high_hi_reg;
            RD_EXT_LOW_HI: reg_rdata <= ext_low_hi_reg;
            RW_EXT_OFFSET_HI: reg_rdata <= ext_offset_hi_reg;
            RW_EXT_OFFSET_LO: reg_rdata <= ext_offset_lo_reg;
            RW_EXT_HIGH_LO: reg_rdata <= ext_high_lo_reg;
            RW_EXT_LOW_LO: reg_rdata <= ext_low_lo_reg;
            RW_EXT_SHUTDOWN: reg_rdata <= ext_shutdown_reg;
            RW_LOCAL_SHUTDOWN: reg_rdata <= local_shutdown_reg;
            RW_HYSTERESIS: reg_rdata <= hysteresis_reg;
            RW_FAULT_QUEUE: reg_rdata <= fault_queue_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // settings straight from register flops
   assign scl_timeout_en = fault_queue_reg[FQ_SCL_TIMEOUT];
   assign sda_timeout_en = fault_queue_reg[FQ_SDA_TIMEOUT];
   assign wide_range = config_reg[CFG_WIDE_RANGE];
   assign beta_disable = config_reg[CFG_BETA_OFF];
endmodule

// file: bench/tmr_register_map_checker.sv
module tmr_chk
   import tmr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // register bus
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // conversion and pins
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic alert_pin_n,
   input wire logic scl_timeout_en,
   input wire logic sda_timeout_en
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy_h, busy_e, mask_h, stby_h, os_q;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   always_ff @(posedge clock) begin
      if (srst || conv_done)
         busy_h <= 1'b0;
      else if (conv_start)
         busy_h <= 1'b1;
   end
   // busy rises on the same edge that launches the start pulse
   assign busy_e = busy_h || conv_start;
   always_ff @(posedge clock) begin
      if (srst) begin
         mask_h <= 1'b0;
         stby_h <= 1'b0;
      end else if (reg_wr && reg_addr == WR_CONFIG) begin
         mask_h <= reg_wdata[CFG_ALERT_MASK] && !reg_wdata[CFG_PIN_SHUTDOWN];
         stby_h <= reg_wdata[CFG_STANDBY];
      end
   end
   always_ff @(posedge clock)
      os_q <= !srst && reg_wr && reg_addr == WR_ONE_SHOT;
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("start pulse held");
   a_no_restart: assert property (busy_h |-> !conv_start)
      else $error("start while busy");
   a_busy_flag: assert property (reg_rd && reg_addr == RD_STATUS
      |=> reg_rdata[ST_BUSY] == $past(busy_e)) else $error("busy bit");
   a_scl_timeout: assert property (reg_wr && reg_addr == RW_FAULT_QUEUE
      |=> scl_timeout_en == $past(reg_wdata[FQ_SCL_TIMEOUT]))
      else $error("scl timeout enable");
   a_sda_timeout: assert property (reg_wr && reg_addr == RW_FAULT_QUEUE
      |=> sda_timeout_en == $past(reg_wdata[FQ_SDA_TIMEOUT]))
      else $error("sda timeout enable");
   a_reserved_zero: assert property (reg_rd && reg_addr == RD_CADENCE
      |=> reg_rdata[7:4] == 4'h0) else $error("rate reserved bits");
   a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h3f
      |=> reg_rdata == 8'h00) else $error("unmapped read");
   a_alert_masked: assert property (mask_h && $past(mask_h, 3)
      |-> alert_pin_n) else $error("masked alert low");
   a_standby_stop: assert property (stby_h && $past(stby_h, 3)
      && !os_q && !$past(os_q) && !$past(os_q, 2) |-> !conv_start)
      else $error("start in standby");
endmodule

// file: bench/tmr_front_model.sv
module tmr_front_model (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // handshake
   input wire logic conv_start,
   output logic conv_done,
   // values and answer delay set by the bench
   input wire logic [3:0] dly,
   input wire logic [7:0] loc_val,
   input wire logic [15:0] ext_val,
   input wire logic open_val,
   // measurement lines
   output logic [7:0] local_meas,
   output logic [15:0] ext_meas,
   output logic ext_open
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run;
   logic [3:0] cnt;
   always_ff @(posedge clock) begin
      conv_done <= 1'b0;
      if (srst) begin
         run <= 1'b0;
      end else if (conv_start) begin
         run <= 1'b1;
         cnt <= 4'h0;
      end else if (run) begin
         cnt <= cnt + 4'h1;
         run <= cnt != dly;
         conv_done <= cnt == dly;
      end
   end
   // lines are only valid with the done pulse; inverted otherwise
   assign local_meas = conv_done ? loc_val : ~loc_val;
   assign ext_meas = conv_done ? ext_val : ~ext_val;
   assign ext_open = conv_done ? open_val : ~open_val;
endmodule

// file: bench/tmr_register_map_tb_top.sv
module tmr_register_map_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tmr_pkg::*;
   localparam int TK = 4;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, local_meas, d;
   logic [15:0] ext_meas;
   logic conv_start, conv_done, ext_open, alert_pin_n, shutdown_output_n;
   logic scl_timeout_en, sda_timeout_en, wide_range, beta_disable;
   logic [7:0] loc_val = 8'h00;
   logic [15:0] ext_val = 16'h0000;
   logic open_val = 1'b0;
   logic [3:0] dly = 4'h1;
   int bad_count = 0;
   int num_checks = 0;
   int n;
   tmr_register_map #(.TICK_LEN(TK)) dut_u (.clock(clock), .srst(srst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
      .conv_done(conv_done), .local_meas(local_meas), .ext_meas(ext_meas),
      .ext_open(ext_open), .alert_pin_n(alert_pin_n),
      .shutdown_output_n(shutdown_output_n), .scl_timeout_en(scl_timeout_en),
      .sda_timeout_en(sda_timeout_en), .wide_range(wide_range),
      .beta_disable(beta_disable));
   tmr_front_model fm_u (.clock(clock), .srst(srst), .conv_start(conv_start),
      .conv_done(conv_done), .dly(dly), .loc_val(loc_val), .ext_val(ext_val),
      .open_val(open_val), .local_meas(local_meas), .ext_meas(ext_meas),
      .ext_open(ext_open));
   initial forever #2 clock = ~clock;
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // counts cycles up to the next start or done pulse, bounded
   task automatic wait_for(input bit done, output int c);
      for (c = 0; c < 5000; c++) begin
         @(negedge clock);
         if ((done ? conv_done : conv_start) === 1'b1)
            return;
      end
      bad_count++;
      end_of_test();
   endtask
   task automatic conv();
      wait_for(1'b1, n);
      repeat (4) @(posedge clock);
      #1;
   endtask
   task automatic t_reset();
      logic [7:0] a [17] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
         8'h08, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h20, 8'h21, 8'h22};
      logic [7:0] v [17] = '{8'h00, 8'h00, 8'h00, 8'h06, 8'h55, 8'h00, 8'h55,
         8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h55, 8'h0a, 8'h01};
      chk("timeouts", 8'h00, {scl_timeout_en, sda_timeout_en});
      for (int i = 0; i < 17; i++) begin
         rd(a[i]);
         chk("reset value", v[i], d);
      end
      $display("reset values done");
   endtask
   task automatic t_access();
      logic [7:0] w [11] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11, 8'h12, 8'h13,
         8'h14, 8'h19, 8'h20, 8'h21};
      logic [7:0] r [11] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h11, 8'h12, 8'h13,
         8'h14, 8'h19, 8'h20, 8'h21};
      for (int i = 0; i < 11; i++) begin
         wr(w[i], 8'h30 + 8'(i));
         wr(r[0], 8'hee);
         rd(r[i]);
         chk("limit rw", 8'h30 + 8'(i), d);
      end
      wr(RD_LOCAL_RESULT, 8'hff);
      rd(RD_LOCAL_RESULT);
      chk("result ro", 8'h00, d);
      wr(WR_CADENCE, 8'hff);
      rd(RD_CADENCE);
      chk("rate mask", 8'h0f, d);
      wr(RW_FAULT_QUEUE, 8'hff);
      rd(RW_FAULT_QUEUE);
      chk("queue mask", 8'hcf, d);
      chk("timeouts on", 8'h03, {scl_timeout_en, sda_timeout_en});
      rd(8'h3f);
      chk("unmapped", 8'h00, d);
      $display("register access done");
   endtask
   task automatic t_cadence();
      logic [7:0] c [5] = '{8'h0a, 8'h08, 8'h07, 8'h06, 8'h0f};
      int p;
      dly <= 4'h9;
      for (int i = 0; i < 5; i++) begin
         wr(WR_CADENCE, c[i]);
         p = PERIOD_MS[c[i] > 10 ? 10 : int'(c[i])] * TK;
         wait_for(1'b0, n);
         wait_for(1'b0, n);
         wait_for(1'b0, n);
         chk("period", 8'h01, 8'(n >= p - 2 && n <= p));
      end
      wait_for(1'b0, n);
      rd(RD_STATUS);
      chk("busy", 8'h80, d & 8'h80);
      dly <= 4'h1;
      $display("cadence done");
   endtask
   task automatic t_flags();
      logic [7:0] a [13] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11, 8'h12, 8'h13,
         8'h14, 8'h19, 8'h20, 8'h21, 8'h22, 8'h0a};
      logic [7:0] v [13] = '{8'h55, 8'h20, 8'h55, 8'h20, 8'h00, 8'h00, 8'h00,
         8'h00, 8'h55, 8'h40, 8'h0a, 8'h01, 8'h0a};
      logic [7:0] lv [6] = '{8'h70, 8'h48, 8'h10, 8'h30, 8'h30, 8'h30};
      logic [15:0] ev [6] = '{16'h3000, 16'h3000, 16'h3000, 16'h6000,
         16'h1000, 16'h3000};
      logic [7:0] sv [6] = '{8'h41, 8'h01, 8'h20, 8'h12, 8'h08, 8'h04};
      for (int i = 0; i < 13; i++)
         wr(a[i], v[i]);
      for (int i = 0; i < 6; i++) begin
         loc_val <= lv[i];
         ext_val <= ev[i];
         open_val <= i == 5;
         conv();
         rd(RD_STATUS);
         conv();
         chk("alert", 8'(sv[i][6:2] == 0), 8'(alert_pin_n));
         chk("shutdown", 8'(sv[i][1:0] == 0), 8'(shutdown_output_n));
         rd(RD_STATUS);
         chk("status", sv[i], d);
         rd(RD_STATUS);
         chk("after clear", sv[i] & 8'h03, d);
         conv();
         rd(RD_STATUS);
         chk("set again", sv[i], d);
      end
      $display("status flags done");
   endtask
   task automatic t_queue();
      logic [7:0] q [4] = '{8'h01, 8'h03, 8'h07, 8'h0f};
      for (int i = 0; i < 4; i++) begin
         wr(RW_FAULT_QUEUE, q[i]);
         loc_val <= 8'h30;
         open_val <= 1'b0;
         conv();
         rd(RD_STATUS);
         loc_val <= 8'h70;
         for (int k = 0; k <= i; k++) begin
            conv();
            chk("queue alert", 8'(k < i), 8'(alert_pin_n));
         end
      end
      $display("fault queue done");
   endtask
   task automatic t_config();
      wr(RW_FAULT_QUEUE, 8'h01);
      wr(WR_CONFIG, 8'h80);
      conv();
      conv();
      chk("masked", 8'h01, 8'(alert_pin_n));
      ext_val <= 16'h6000;
      wr(WR_CONFIG, 8'ha0);
      conv();
      conv();
      chk("pin mode", 8'h00, 8'(alert_pin_n));
      ext_val <= 16'h3000;
      wr(WR_CONFIG, 8'h5c);
      rd(RD_CONFIG);
      chk("config", 8'h54, d);
      chk("range beta", 8'h03, {wide_range, beta_disable});
      n = 0;
      repeat (400) begin
         @(negedge clock);
         n += int'(conv_start === 1'b1);
      end
      chk("standby starts", 8'h00, 8'(n));
      wr(WR_ONE_SHOT, 8'h00);
      conv();
      wr(WR_LOCAL_HIGH, 8'h80);
      rd(RD_STATUS);
      wr(WR_LOCAL_HIGH, 8'h60);
      repeat (4) @(posedge clock);
      rd(RD_STATUS);
      chk("standby limit", 8'h40, d & 8'h40);
      $display("config and standby done");
   endtask
   initial begin
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_access();
      t_cadence();
      t_flags();
      t_queue();
      t_config();
      end_of_test();
   end
endmodule
bind tmr_register_map tmr_chk chk_u (.clock(clock), .srst(srst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
   .conv_done(conv_done), .alert_pin_n(alert_pin_n),
   .scl_timeout_en(scl_timeout_en), .sda_timeout_en(sda_timeout_en));
